// [design/sac_bit_clock.sv]
// half bit-period tick generator from system divider or rc clock pin
`default_nettype none
module sac_bit_clock (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [2:0] clockSelect,
   input wire logic rcClock,
   input wire logic run,
   output logic halfTick,
   output logic rcSelected
);
   logic rcMeta_q;
   logic rcSync_q;
   logic rcPrev_q;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic [5:0] halfLimit;
   logic divTick;

   function automatic logic [5:0] limitOf(input logic [2:0] sel);
      logic [5:0] l;
      l = sac_pkg::HALF_DIV2;
      case (sel)
         3'h1: l = sac_pkg::HALF_DIV8;
         3'h2: l = sac_pkg::HALF_DIV32;
         3'h4: l = sac_pkg::HALF_DIV4;
         3'h5: l = sac_pkg::HALF_DIV16;
         3'h6: l = sac_pkg::HALF_DIV64;
         default: l = sac_pkg::HALF_DIV2;
      endcase
      return l;
   endfunction : limitOf

   assign rcSelected = (clockSelect[1:0] == sac_pkg::CLK_RC_LOW);
   assign halfLimit = limitOf(clockSelect);
   assign divTick = run & (cnt_q == halfLimit - 6'h01);
   assign cnt_d = (!run || divTick) ? 6'h00 : cnt_q + 6'h01;
   // each rc edge is half a bit period
   assign halfTick = run & (rcSelected ? (rcSync_q ^ rcPrev_q) : divTick);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rcMeta_q <= 1'b0;
         rcSync_q <= 1'b0;
         rcPrev_q <= 1'b0;
         cnt_q <= 6'h00;
      end else begin
         rcMeta_q <= rcClock;
         rcSync_q <= rcMeta_q;
         rcPrev_q <= rcSync_q;
         cnt_q <= cnt_d;
      end
   end
endmodule : sac_bit_clock
`default_nettype wire

// [design/sac_converter.sv]
// successive-approximation conversion control with APB registers
`default_nettype none
module sac_converter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rcClock,
   input wire logic sleepRequest,
   input wire logic compareAbove,
   input wire logic specialTrigger,
   output logic converterPowered,
   output logic holdSample,
   output logic [9:0] trialCode,
   output logic [4:0] channelCode,
   output logic pinChannelSel,
   output logic tempSel,
   output logic dacSel,
   output logic fixedRefSel,
   output logic posRefSupply,
   output logic posRefPin,
   output logic posRefFixed,
   output logic negRefPin,
   output logic timerClear,
   output logic conversionDone,
   output logic wakeRequest
);
   ////////////////////////////////////////////////////////////////////////////
   sac_pkg::sac_state_t stateQ;
   sac_pkg::sac_state_t stateD;
   logic enQ, goQ, doneQ, irqEnQ;
   logic [4:0] chanQ;
   logic [7:0] ctrl1Q, resHighQ, resLowQ;
   logic [9:0] sar_q;
   logic [3:0] bitIdx_q;
   logic lastBit_q, anyBit_q, allBits_q;
   logic [4:0] halfCnt_q;
   logic [2:0] delayCnt_q;
   logic sleepMeta_q, sleepSync_q, cmpSync_q;
   logic [31:0] prdata_q;
   logic timerClear_q, conversionDone_q;

   function automatic logic [7:0] fmtHigh(input logic [9:0] r, input logic right);
      return right ? {6'h00, r[9:8]} : r[9:2];
   endfunction : fmtHigh
   function automatic logic [7:0] fmtLow(input logic [9:0] r, input logic right);
      return right ? r[7:0] : {r[1:0], 6'h00};
   endfunction : fmtLow
   function automatic logic [9:0] sarStep(input logic [9:0] s, input logic [3:0] idx,
         input logic keep);
      logic [9:0] r;
      r = s;
      r[idx] = keep;
      if (idx != 4'h0) begin
         r[idx - 4'h1] = 1'b1;
      end
      return r;
   endfunction : sarStep

   function automatic logic [9:0] fillPartial(input logic [9:0] s, input logic [3:0] idx,
         input logic last, input logic any, input logic all);
      logic [9:0] r;
      r = s;
      for (int i = 0; i < 10; i++) begin
         if (!all && (i <= int'(idx))) begin
            r[i] = any & last;
         end
      end
      return r;
   endfunction : fillPartial

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic hitCtrl0, hitCtrl1, hitResHigh, hitResLow, hitStatus, mapped, apbWrite;
   logic wrCtrl0, wrCtrl1, wrResHigh, wrResLow, wrStatus;
   logic [31:0] readMux;
   assign hitCtrl0 = (paddr == sac_pkg::ADDR_CTRL0);
   assign hitCtrl1 = (paddr == sac_pkg::ADDR_CTRL1);
   assign hitResHigh = (paddr == sac_pkg::ADDR_RES_HIGH);
   assign hitResLow = (paddr == sac_pkg::ADDR_RES_LOW);
   assign hitStatus = (paddr == sac_pkg::ADDR_STATUS);
   assign mapped = hitCtrl0 | hitCtrl1 | hitResHigh | hitResLow | hitStatus;
   assign apbWrite = psel & penable & pwrite & mapped;
   assign wrCtrl0 = apbWrite & hitCtrl0;
   assign wrCtrl1 = apbWrite & hitCtrl1;
   assign wrResHigh = apbWrite & hitResHigh;
   assign wrResLow = apbWrite & hitResLow;
   assign wrStatus = apbWrite & hitStatus;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_q;

   // unimplemented bits read zero
   assign readMux = hitCtrl0 ? {24'h000000, 1'b0, chanQ, goQ, enQ} :
      hitCtrl1 ? {24'h000000, ctrl1Q} :
      hitResHigh ? {24'h000000, resHighQ} :
      hitResLow ? {24'h000000, resLowQ} :
      hitStatus ? {30'h0000000, irqEnQ, doneQ} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // configuration decode
   logic rcSel, halfTick, justifyRight;
   logic [1:0] posRef;
   assign justifyRight = ctrl1Q[sac_pkg::CTRL1_JUSTIFY];
   assign posRef = ctrl1Q[1:0];
   assign channelCode = chanQ;
   assign pinChannelSel = (chanQ <= sac_pkg::CH_LAST_PIN);
   assign tempSel = (chanQ == sac_pkg::CH_TEMP);
   assign dacSel = (chanQ == sac_pkg::CH_DAC);
   assign fixedRefSel = (chanQ == sac_pkg::CH_FIXED_REF);
   assign posRefSupply = (posRef == sac_pkg::PREF_SUPPLY);
   assign posRefPin = (posRef == sac_pkg::PREF_PIN);
   assign posRefFixed = (posRef == sac_pkg::PREF_FIXED);
   assign negRefPin = ctrl1Q[sac_pkg::CTRL1_NREF];

   sac_bit_clock u_bit_clock (
      .clk(clk),
      .rst_b(rst_b),
      .clockSelect(ctrl1Q[sac_pkg::CTRL1_CLK_LSB +: 3]),
      .rcClock(rcClock),
      .run(stateQ == sac_pkg::ST_CONV),
      .halfTick(halfTick),
      .rcSelected(rcSel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencing
   logic idle, busy, conv, enNext, sleepBlock, trigNow, startNow, swAbort, stopNow;
   logic resolveNow, finishNow, loadPartial;
   logic [9:0] partialCode;
   assign idle = (stateQ == sac_pkg::ST_IDLE);
   assign busy = ~idle;
   assign conv = (stateQ == sac_pkg::ST_CONV);
   assign enNext = wrCtrl0 ? pwdata[sac_pkg::CTRL0_ENABLE] : enQ;
   assign sleepBlock = sleepSync_q & ~rcSel;
   assign trigNow = idle & specialTrigger & enNext & ~sleepBlock;
   assign startNow = idle & enNext & ~sleepBlock
      & ((wrCtrl0 & pwdata[sac_pkg::CTRL0_GO]) | specialTrigger);
   assign swAbort = busy & wrCtrl0 & ~pwdata[sac_pkg::CTRL0_GO];
   // sleep off the rc clock or disabling drops the conversion
   assign stopNow = busy & (swAbort | sleepBlock | (wrCtrl0 & ~enNext));
   assign resolveNow = conv & halfTick & halfCnt_q[0] & ~allBits_q
      & (halfCnt_q >= sac_pkg::HALF_FIRST_RESOLVE);
   assign finishNow = conv & halfTick & (halfCnt_q == sac_pkg::HALF_LAST);
   assign loadPartial = swAbort & ~finishNow;
   assign partialCode = fillPartial(sar_q, bitIdx_q, lastBit_q, anyBit_q, allBits_q);

   always_comb begin
      stateD = stateQ;
      case (stateQ)
         sac_pkg::ST_IDLE: begin
            if (startNow) begin
               stateD = rcSel ? sac_pkg::ST_DELAY : sac_pkg::ST_CONV;
            end
         end
         sac_pkg::ST_DELAY: begin
            if (stopNow) begin
               stateD = sac_pkg::ST_IDLE;
            end else if (delayCnt_q == sac_pkg::DELAY_LAST) begin
               stateD = sac_pkg::ST_CONV;
            end
         end
         sac_pkg::ST_CONV: begin
            if (stopNow || finishNow) begin
               stateD = sac_pkg::ST_IDLE;
            end
         end
         default: stateD = sac_pkg::ST_IDLE;
      endcase
   end

   // rc clock in sleep keeps running until done, then powers down unless waking
   assign converterPowered = enQ & ~(sleepSync_q & (~rcSel | (idle & ~irqEnQ)));
   assign holdSample = conv;
   assign trialCode = sar_q;
   assign timerClear = timerClear_q;
   assign conversionDone = conversionDone_q;
   assign wakeRequest = sleepSync_q & doneQ & irqEnQ;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleepMeta_q <= 1'b0;
         sleepSync_q <= 1'b0;
         cmpSync_q <= 1'b0;
         prdata_q <= 32'h00000000;
         timerClear_q <= 1'b0;
         conversionDone_q <= 1'b0;
      end else begin
         sleepMeta_q <= sleepRequest;
         sleepSync_q <= sleepMeta_q;
         // comparator follows trialCode within a cycle: one register keeps div2 in step
         cmpSync_q <= compareAbove;
         prdata_q <= (psel & ~penable & ~pwrite) ? readMux : prdata_q;
         timerClear_q <= trigNow;
         conversionDone_q <= finishNow;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stateQ <= sac_pkg::ST_IDLE;
         enQ <= sac_pkg::CTRL0_RESET[sac_pkg::CTRL0_ENABLE];
         goQ <= sac_pkg::CTRL0_RESET[sac_pkg::CTRL0_GO];
         chanQ <= sac_pkg::CTRL0_RESET[sac_pkg::CTRL0_CHAN_LSB +: 5];
         ctrl1Q <= sac_pkg::CTRL1_RESET;
         doneQ <= 1'b0;
         irqEnQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         if (wrCtrl0) begin
            enQ <= pwdata[sac_pkg::CTRL0_ENABLE];
            chanQ <= pwdata[sac_pkg::CTRL0_CHAN_LSB +: 5];
         end
         if (wrCtrl1) begin
            ctrl1Q <= {pwdata[7:4], 1'b0, pwdata[2:0]};
         end
         if (startNow) begin
            goQ <= 1'b1;
         end else if (finishNow || stopNow) begin
            goQ <= 1'b0;
         end
         // completion wins over a clearing write
         doneQ <= finishNow | (doneQ & ~(wrStatus & ~pwdata[sac_pkg::STATUS_DONE]));
         if (wrStatus) begin
            irqEnQ <= pwdata[sac_pkg::STATUS_IRQ_EN];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resHighQ <= sac_pkg::RESULT_RESET;
         resLowQ <= sac_pkg::RESULT_RESET;
      end else if (finishNow) begin
         resHighQ <= fmtHigh(sar_q, justifyRight);
         resLowQ <= fmtLow(sar_q, justifyRight);
      end else if (loadPartial) begin
         resHighQ <= fmtHigh(partialCode, justifyRight);
         resLowQ <= fmtLow(partialCode, justifyRight);
      end else begin
         resHighQ <= wrResHigh ? pwdata[7:0] : resHighQ;
         resLowQ <= wrResLow ? pwdata[7:0] : resLowQ;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sar_q <= 10'h000;
         bitIdx_q <= sac_pkg::MSB_INDEX;
         lastBit_q <= 1'b0;
         anyBit_q <= 1'b0;
         allBits_q <= 1'b0;
         halfCnt_q <= 5'h00;
         delayCnt_q <= 3'h0;
      end else if (startNow) begin
         sar_q <= 10'h200;
         bitIdx_q <= sac_pkg::MSB_INDEX;
         anyBit_q <= 1'b0;
         allBits_q <= 1'b0;
         halfCnt_q <= 5'h00;
         delayCnt_q <= 3'h0;
      end else begin
         delayCnt_q <= (stateQ == sac_pkg::ST_DELAY) ? delayCnt_q + 3'h1 : 3'h0;
         halfCnt_q <= (conv & halfTick) ? halfCnt_q + 5'h01 : halfCnt_q;
         if (resolveNow) begin
            sar_q <= sarStep(sar_q, bitIdx_q, cmpSync_q);
            lastBit_q <= cmpSync_q;
            anyBit_q <= 1'b1;
            allBits_q <= (bitIdx_q == 4'h0);
            bitIdx_q <= (bitIdx_q == 4'h0) ? 4'h0 : bitIdx_q - 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_delaying;
      (stateQ == sac_pkg::ST_DELAY) [*4];
   endsequence

   property p_finish;
      finishNow |=> !goQ && doneQ && conversionDone && idle;
   endproperty
   a_finish: assert property (p_finish) else $error("completion flags wrong");
   property p_left_format;
      finishNow && !justifyRight |=> resHighQ == $past(sar_q[9:2])
         && resLowQ == {$past(sar_q[1:0]), 6'h00};
   endproperty
   a_left_format: assert property (p_left_format) else $error("left format wrong");
   property p_right_format;
      finishNow && justifyRight |=> resHighQ[7:2] == 6'h00 && resLowQ == $past(sar_q[7:0]);
   endproperty
   a_right_format: assert property (p_right_format) else $error("right format wrong");
   property p_abort_partial;
      loadPartial |=> !goQ && idle && resHighQ == fmtHigh($past(partialCode), justifyRight);
   endproperty
   a_abort_partial: assert property (p_abort_partial) else $error("abort load wrong");
   property p_rc_delay;
      startNow && rcSel && !wrCtrl1 |=> s_delaying ##1 (conv || idle);
   endproperty
   a_rc_delay: assert property (p_rc_delay) else $error("rc start delay wrong");
   property p_sleep_abort;
      sleepBlock && busy && !wrCtrl0 |=> idle && !goQ && !converterPowered;
   endproperty
   a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort wrong");
   property p_trigger;
      trigNow |=> goQ && timerClear;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger start wrong");
   property p_step;
      resolveNow |=> sar_q[$past(bitIdx_q)] == $past(cmpSync_q) && anyBit_q;
   endproperty
   a_step: assert property (p_step) else $error("bit step wrong");
   property p_off;
      !enQ |-> !converterPowered;
   endproperty
   a_off: assert property (p_off) else $error("disabled but powered");
   property p_unimpl;
      !ctrl1Q[3] && !(tempSel && pinChannelSel);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("reserved bit set");
   property p_length;
      conv && halfTick && halfCnt_q < sac_pkg::HALF_LAST && !stopNow |=> conv;
   endproperty
   a_length: assert property (p_length) else $error("conversion ended early");
endmodule : sac_converter
`default_nettype wire

// [shared/sac_pkg.sv]
// shared constants and types of the conversion sequencer
`default_nettype none
package sac_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
   localparam logic [7:0] ADDR_RES_LOW = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // reset values
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   // field positions
   localparam int CTRL0_ENABLE = 0;
   localparam int CTRL0_GO = 1;
   localparam int CTRL0_CHAN_LSB = 2;
   localparam int CTRL1_NREF = 2;
   localparam int CTRL1_CLK_LSB = 4;
   localparam int CTRL1_JUSTIFY = 7;
   localparam int STATUS_DONE = 0;
   localparam int STATUS_IRQ_EN = 1;
   // channel, reference and clock codes
   localparam logic [4:0] CH_LAST_PIN = 5'h0B;
   localparam logic [4:0] CH_TEMP = 5'h1D;
   localparam logic [4:0] CH_DAC = 5'h1E;
   localparam logic [4:0] CH_FIXED_REF = 5'h1F;
   localparam logic [1:0] PREF_SUPPLY = 2'h0;
   localparam logic [1:0] PREF_PIN = 2'h2;
   localparam logic [1:0] PREF_FIXED = 2'h3;
   localparam logic [1:0] CLK_RC_LOW = 2'h3;
   // half bit-period lengths in system clocks per divider code
   localparam logic [5:0] HALF_DIV2 = 6'h01;
   localparam logic [5:0] HALF_DIV4 = 6'h02;
   localparam logic [5:0] HALF_DIV8 = 6'h04;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV32 = 6'h10;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   // 11.5 bit periods: half periods 0..22, bits resolved at odd 3..21
   localparam logic [4:0] HALF_FIRST_RESOLVE = 5'h03;
   localparam logic [4:0] HALF_LAST = 5'h16;
   localparam logic [3:0] MSB_INDEX = 4'h9;
   // one instruction cycle of extra start delay on the rc clock
   localparam int CLK_PERIOD_NS = 4;
   localparam int INSTR_TIME_NS = 16;
   localparam int INSTR_CLKS = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] DELAY_LAST = 3'(INSTR_CLKS - 1);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DELAY = 3'b010,
      ST_CONV = 3'b100
   } sac_state_t;
endpackage : sac_pkg
`default_nettype wire

// [verification/sac_analog_model.sv]
// comparator and rc oscillator on the analog side of the sequencer
`default_nettype none
module sac_analog_model (
   input wire logic [9:0] level,
   input wire logic [9:0] trialCode,
   output logic compareAbove,
   output logic rcClock
);
   timeunit 1ns;
   timeprecision 1ps;
   // input at or above the trial word
   assign compareAbove = (level >= trialCode);
   // free running, unrelated in phase to clk
   initial begin
      rcClock = 1'b0;
      forever #21.3 rcClock = ~rcClock;
   end
endmodule : sac_analog_model
`default_nettype wire

// [verification/test_sar_adc_conversion_control.sv]
// self-checking bench of the conversion sequencer
`default_nettype none
module test_sar_adc_conversion_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A0 = sac_pkg::ADDR_CTRL0;
   localparam logic [7:0] A1 = sac_pkg::ADDR_CTRL1;
   localparam logic [7:0] AH = sac_pkg::ADDR_RES_HIGH;
   localparam logic [7:0] AL = sac_pkg::ADDR_RES_LOW;
   localparam logic [7:0] AS = sac_pkg::ADDR_STATUS;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rcClock, sleepRequest;
   logic compareAbove, specialTrigger, converterPowered, holdSample, pinChannelSel;
   logic tempSel, dacSel, fixedRefSel, posRefSupply, posRefPin, posRefFixed, negRefPin;
   logic timerClear, conversionDone, wakeRequest;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0] trialCode, level;
   logic [4:0] channelCode;
   logic [33:0] notes[$];
   int errorCnt, totalChecks, cycles, hsLen, expH;
   int halfOf[8] = '{1, 4, 16, 0, 2, 8, 32, 0};
   logic [4:0] chans[7] = '{5'h00, 5'h0B, 5'h0C, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
   logic [2:0] codes[8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};

   sac_converter i_sac_converter (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rcClock(rcClock), .sleepRequest(sleepRequest), .compareAbove(compareAbove),
      .specialTrigger(specialTrigger), .converterPowered(converterPowered),
      .holdSample(holdSample), .trialCode(trialCode), .channelCode(channelCode),
      .pinChannelSel(pinChannelSel), .tempSel(tempSel), .dacSel(dacSel),
      .fixedRefSel(fixedRefSel), .posRefSupply(posRefSupply), .posRefPin(posRefPin),
      .posRefFixed(posRefFixed), .negRefPin(negRefPin), .timerClear(timerClear),
      .conversionDone(conversionDone), .wakeRequest(wakeRequest)
   );
   sac_analog_model i_sac_analog_model (
      .level(level), .trialCode(trialCode), .compareAbove(compareAbove), .rcClock(rcClock)
   );
   ////////////////////////////////////////////////////////////
   task automatic closeOut();
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : closeOut
   task automatic bad(input string m);
      errorCnt++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task automatic chk(input logic c, input string m);
      totalChecks++;
      if (c !== 1'b1) bad(m);
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
      logic [31:0] r;
      notes.push_back({1'b1, err, e});
      apb(1'b0, a, 32'h0, r);
   endtask : rd
   task automatic poll();
      logic [31:0] r;
      for (int n = 0; n < 900; n++) begin
         notes.push_back(34'h0);
         apb(1'b0, A0, 32'h0, r);
         if (r[1] === 1'b0) return;
      end
      bad("go stuck");
   endtask : poll
   task automatic conv(input logic [2:0] cs, input logic just, input logic [9:0] v);
      level <= v;
      expH = halfOf[cs];
      wr(A1, {24'h0, just, cs, 4'h0});
      wr(A0, 32'h01);
      repeat (8) @(posedge clk);
      wr(A0, 32'h03);
      chk(holdSample === (cs[1:0] != 2'h3), "start delay");
      poll();
      rd(AH, just ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
      rd(AL, just ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0});
      rd(AS, 32'h1);
      wr(AS, 32'h0);
      rd(AS, 32'h0);
   endtask : conv
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // read checker, timeout and conversion length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         bad("timeout");
         closeOut();
      end
      if (psel && penable && pready && !pwrite && notes.size() != 0) begin
         if (notes[0][33]) begin
            totalChecks++;
            if (prdata !== notes[0][31:0] || pslverr !== notes[0][32]) bad("read data");
         end
         void'(notes.pop_front());
      end
      if (holdSample === 1'b1) hsLen++;
      else if (hsLen != 0) begin
         if (expH != 0) chk(hsLen >= 22 * expH && hsLen <= 23 * expH + 2, "length");
         hsLen = 0;
      end
   end
   initial begin
      int n;
      {psel, penable, pwrite, sleepRequest, specialTrigger, rst_b} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      level = 10'h0;
      void'($urandom(32'h618988C1));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(A0, 32'h0);
      rd(A1, 32'h0);
      rd(8'h14, 32'h0, 1'b1);
      wr(AH, 32'hA5);
      rd(AH, 32'hA5);
      wr(A0, 32'hFFFFFFFC);
      rd(A0, 32'h7C);
      wr(A1, 32'hFF);
      rd(A1, 32'hF7);
      foreach (chans[i]) begin
         wr(A0, {25'h0, chans[i], 2'h1});
         chk({pinChannelSel, tempSel, dacSel, fixedRefSel, channelCode} === {chans[i] <= 5'h0B,
            chans[i] == 5'h1D, chans[i] == 5'h1E, chans[i] == 5'h1F, chans[i]}, "chan");
         chk(converterPowered === 1'b1, "power on");
      end
      for (int p = 0; p < 4; p++) begin
         wr(A1, {29'h0, p[0], p[1:0]});
         chk({posRefSupply, posRefPin, posRefFixed, negRefPin} ===
            {p == 0, p == 2, p == 3, p[0]}, "refs");
      end
      wr(A0, 32'h0);
      chk(converterPowered === 1'b0, "power off");
      $display("registers done");
      foreach (codes[i]) conv(codes[i], i[0], 10'($urandom));
      conv(3'h1, 1'b0, 10'h3FF);
      conv(3'h0, 1'b1, 10'h000);
      $display("conversions done");
      level <= 10'h155;
      expH = 4;
      wr(A1, 32'h90);
      wr(A0, 32'h01);
      repeat (8) @(posedge clk);
      specialTrigger <= 1'b1;
      @(posedge clk);
      specialTrigger <= 1'b0;
      @(posedge clk);
      chk(timerClear === 1'b1, "timer clear");
      rd(A0, 32'h03);
      poll();
      rd(AH, 32'h01);
      rd(AL, 32'h55);
      wr(AS, 32'h0);
      $display("trigger done");
      // abort lands after two resolved ones: the rest fill with one
      expH = 0;
      level <= 10'h300;
      wr(A1, 32'hE0);
      wr(A0, 32'h03);
      repeat (250) @(posedge clk);
      wr(A0, 32'h01);
      rd(A0, 32'h01);
      rd(AH, 32'h03);
      rd(AL, 32'hFF);
      wr(A0, 32'h03);
      sleepRequest <= 1'b1;
      repeat (8) @(posedge clk);
      chk(converterPowered === 1'b0, "sleep power");
      rd(A0, 32'h01);
      sleepRequest <= 1'b0;
      $display("abort done");
      level <= 10'($urandom);
      wr(AS, 32'h2);
      wr(A1, 32'h30);
      wr(A0, 32'h03);
      sleepRequest <= 1'b1;
      for (n = 0; n < 400 && wakeRequest !== 1'b1; n++) @(posedge clk);
      chk(wakeRequest === 1'b1, "wake");
      sleepRequest <= 1'b0;
      rd(AH, {24'h0, level[9:2]});
      wr(AS, 32'h0);
      wr(A0, 32'h03);
      sleepRequest <= 1'b1;
      for (n = 0; n < 400 && conversionDone !== 1'b1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(n < 400 && converterPowered === 1'b0 && wakeRequest === 1'b0, "rc sleep");
      rd(A0, 32'h01);
      sleepRequest <= 1'b0;
      $display("sleep done");
      wr(A1, 32'hE0);
      wr(A0, 32'h03);
      repeat (20) @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk(converterPowered === 1'b0 && holdSample === 1'b0, "reset");
      rd(A0, 32'h0);
      rd(A1, 32'h0);
      $display("reset done");
      closeOut();
   end
endmodule : test_sar_adc_conversion_control
`default_nettype wire
